// ### logic/clkgen_regs_cfg.svh
// constants for the upper register bytes of the clock generator control bank
// assumes inclusion by bare name from the logic folder
`ifndef CLKGEN_REGS_CFG_SVH
`define CLKGEN_REGS_CFG_SVH

// ==========================================================
// register indices
`define IDX_EDGE_RATE    3'h2
`define IDX_REF_CTRL     3'h3
`define IDX_RSVD_ONES    3'h4
`define IDX_REV_MAKER    3'h5
`define IDX_FAMILY_PART  3'h6
`define IDX_RB_LENGTH    3'h7
`define IDX_FIRST        3'h2

// ==========================================================
// reset and fixed values
`define RST_EDGE_RATE    4'hf
`define RST_REF_SLEW     2'h1
`define RST_REF_RUN_PD   1'h0
`define RST_REF_OE       1'h1
`define RST_RB_LENGTH    5'h08
`define RSVD_ONES_VAL    8'hff
`define RSVD_EDGE_HI     4'hf
`define RSVD_REF_LO      4'hf
`define RSVD_LEN_HI      3'h0
`define UNMAPPED_VAL     8'h00

// arbitrary identity values, not those of any real part
`define REVISION_CODE    4'h3
`define MAKER_CODE       4'h5
`define FAMILY_TYPE      2'h2
`define PART_CODE        6'h2a

// ==========================================================
// field positions
`define EDGE_LSB         0
`define EDGE_MSB         3
`define REF_OE_BIT       4
`define REF_RUN_PD_BIT   5
`define REF_SLEW_LSB     6
`define REF_SLEW_MSB     7
`define LEN_MSB          4

`endif

// ### logic/clkgen_regs_pkg.sv
// types shared by the upper register bank and its helpers
// assumes the cfg header sets the fixed values
package clkgen_regs_pkg;

	// ==========================================================
	// reference slew encodings
	typedef enum logic [1:0] {
		REF_SLEWEST = 2'h0,
		REF_SLOW    = 2'h1,
		REF_FAST    = 2'h2,
		REF_FASTER  = 2'h3
	} ref_slew_t;

	// ==========================================================
	// register access carrier from the serial engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] idx;
		logic [7:0] wdata;
	} reg_req_t;

	// settings steering the output drivers
	typedef struct packed {
		logic [3:0] diff_edge_fast;
		ref_slew_t  ref_slew;
		logic       ref_run_in_pd;
		logic       ref_oe;
	} clk_ctrl_t;

	// ==========================================================
	// block read sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_COUNT = 3'h2,
		ST_DATA  = 3'h4
	} blk_state_t;

endpackage

// ### logic/reg_readback.sv
// read mux for the upper register bytes
// assumes current register contents arrive combinationally
`timescale 1ns/1ps
`include "clkgen_regs_cfg.svh"

module reg_readback (
	input  wire logic [2:0]                  idx,
	input  wire clkgen_regs_pkg::clk_ctrl_t  ctrl,
	input  wire logic [4:0]                  rb_len,
	output logic [7:0]                       rdata
);

	// ==========================================================
	// fixed fields ignore writes, always read their constants
	always_comb begin
		case (idx)
			`IDX_EDGE_RATE:   rdata = {`RSVD_EDGE_HI, ctrl.diff_edge_fast};
			`IDX_REF_CTRL:    rdata = {ctrl.ref_slew, ctrl.ref_run_in_pd,
			                          ctrl.ref_oe, `RSVD_REF_LO};
			`IDX_RSVD_ONES:   rdata = `RSVD_ONES_VAL;
			`IDX_REV_MAKER:   rdata = {`REVISION_CODE, `MAKER_CODE};
			`IDX_FAMILY_PART: rdata = {`FAMILY_TYPE, `PART_CODE};
			`IDX_RB_LENGTH:   rdata = {`RSVD_LEN_HI, rb_len};
			default:          rdata = `UNMAPPED_VAL;
		endcase
	end

endmodule

// ### logic/block_read_seq.sv
// sequencer for a block read: count byte first, then data from the start index
// assumes the serial engine pulses start and next on acknowledged bytes
`timescale 1ns/1ps
`include "clkgen_regs_cfg.svh"

module block_read_seq (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic                          start,
	input  wire logic                          next,
	input  wire logic                          stop,
	input  wire logic [2:0]                    start_idx,
	input  wire logic [4:0]                    rb_len,
	output logic [2:0]                         rd_idx,
	output logic                               send_count,
	output logic                               active
);

	clkgen_regs_pkg::blk_state_t state_ff, nxt_state;
	logic [2:0] idx_ff, nxt_idx;
	logic [4:0] left_ff, nxt_left;

	// ==========================================================
	// next state
	always_comb begin
		nxt_state = state_ff;
		nxt_idx   = idx_ff;
		nxt_left  = left_ff;
		case (state_ff)
			clkgen_regs_pkg::ST_IDLE: begin
				if (start) begin
					nxt_state = clkgen_regs_pkg::ST_COUNT;
					nxt_idx   = start_idx;
					nxt_left  = rb_len;
				end
			end
			clkgen_regs_pkg::ST_COUNT: begin
				if (stop)
					nxt_state = clkgen_regs_pkg::ST_IDLE;
				else if (next)
					nxt_state = clkgen_regs_pkg::ST_DATA;
			end
			clkgen_regs_pkg::ST_DATA: begin
				// host ends with nack and stop; extra bytes just keep walking
				if (stop) begin
					nxt_state = clkgen_regs_pkg::ST_IDLE;
				end else if (next) begin
					nxt_idx  = idx_ff + 3'h1;
					nxt_left = (left_ff == 5'h0) ? 5'h0 : left_ff - 5'h1;
				end
			end
			default: nxt_state = clkgen_regs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= clkgen_regs_pkg::ST_IDLE;
			idx_ff   <= `IDX_FIRST;
			left_ff  <= `RST_RB_LENGTH;
		end else begin
			state_ff <= nxt_state;
			idx_ff   <= nxt_idx;
			left_ff  <= nxt_left;
		end
	end

	assign rd_idx     = idx_ff;
	assign send_count = (state_ff == clkgen_regs_pkg::ST_COUNT);
	assign active     = (state_ff != clkgen_regs_pkg::ST_IDLE);

endmodule

// ### logic/clockgen_smbus_ctrl_regs_hi.sv
// upper control and identification bytes (indices 2..7) of the clock generator
// assumes the serial protocol engine delivers decoded byte writes and read steps
`timescale 1ns/1ps
`include "clkgen_regs_cfg.svh"

module clockgen_smbus_ctrl_regs_hi (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire clkgen_regs_pkg::reg_req_t     req,
	input  wire logic                          blk_rd_start,
	input  wire logic                          blk_rd_next,
	input  wire logic                          bus_stop,
	input  wire logic [2:0]                    blk_start_idx,
	input  wire logic                          power_down,
	output logic [7:0]                         rd_byte,
	output logic                               rd_busy,
	output logic [3:0]                         diff_edge_fast,
	output logic [1:0]                         ref_slew,
	output logic                               ref_enable,
	output logic [4:0]                         readback_len
);

	// ==========================================================
	// register state
	clkgen_regs_pkg::clk_ctrl_t ctrl_ff, nxt_ctrl;
	logic [4:0]                 len_ff, nxt_len;
	logic [7:0]                 rd_ff, nxt_rd;
	logic                       busy_ff;
	logic                       ref_en_ff, nxt_ref_en;
	logic [2:0]                 seq_idx;
	logic                       seq_count;
	logic                       seq_active;
	logic [2:0]                 mux_idx;
	logic [7:0]                 mux_data;

	function automatic logic hit(input clkgen_regs_pkg::reg_req_t r, input logic [2:0] i);
		hit = r.wr && (r.idx == i);
	endfunction

	// ==========================================================
	// block read sequencing
	block_read_seq u_seq (
		.clk        (clk),
		.nrst       (nrst),
		.start      (blk_rd_start),
		.next       (blk_rd_next),
		.stop       (bus_stop),
		.start_idx  (blk_start_idx),
		.rb_len     (len_ff),
		.rd_idx     (seq_idx),
		.send_count (seq_count),
		.active     (seq_active)
	);

	// single reads use the request index, block reads the walking one
	assign mux_idx = seq_active ? seq_idx : req.idx;

	reg_readback u_rb (
		.idx   (mux_idx),
		.ctrl  (ctrl_ff),
		.rb_len(len_ff),
		.rdata (mux_data)
	);

	// ==========================================================
	// write decode; each byte of a block write arrives as its own req.wr
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_len  = len_ff;
		if (hit(req, `IDX_EDGE_RATE))
			nxt_ctrl.diff_edge_fast = req.wdata[`EDGE_MSB:`EDGE_LSB];
		if (hit(req, `IDX_REF_CTRL)) begin
			nxt_ctrl.ref_slew      = clkgen_regs_pkg::ref_slew_t'(
			                         req.wdata[`REF_SLEW_MSB:`REF_SLEW_LSB]);
			nxt_ctrl.ref_run_in_pd = req.wdata[`REF_RUN_PD_BIT];
			nxt_ctrl.ref_oe        = req.wdata[`REF_OE_BIT];
		end
		if (hit(req, `IDX_RB_LENGTH))
			nxt_len = req.wdata[`LEN_MSB:0];
		// indices 4..6 and reserved bits have no storage, so writes vanish
	end

	// ==========================================================
	// read data and reference gating
	always_comb begin
		nxt_rd = rd_ff;
		if (seq_count)
			nxt_rd = {`RSVD_LEN_HI, len_ff};
		else if (seq_active || req.rd)
			nxt_rd = mux_data;
		// output held low when disabled, or when powered down without wake run
		nxt_ref_en = ctrl_ff.ref_oe && (!power_down || ctrl_ff.ref_run_in_pd);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_ff.diff_edge_fast <= `RST_EDGE_RATE;
			ctrl_ff.ref_slew       <= clkgen_regs_pkg::ref_slew_t'(`RST_REF_SLEW);
			ctrl_ff.ref_run_in_pd  <= `RST_REF_RUN_PD;
			ctrl_ff.ref_oe         <= `RST_REF_OE;
			len_ff                 <= `RST_RB_LENGTH;
			rd_ff                  <= `UNMAPPED_VAL;
			busy_ff                <= 1'b0;
			ref_en_ff              <= 1'b0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			len_ff    <= nxt_len;
			rd_ff     <= nxt_rd;
			busy_ff   <= seq_active;
			ref_en_ff <= nxt_ref_en;
		end
	end

	// ==========================================================
	// outputs, all from flip-flops
	assign rd_byte        = rd_ff;
	assign rd_busy        = busy_ff;
	assign diff_edge_fast = ctrl_ff.diff_edge_fast;
	assign ref_slew       = ctrl_ff.ref_slew;
	assign ref_enable     = ref_en_ff;
	assign readback_len   = len_ff;

endmodule

// ### tb/regs_hi_checker.sv
// assertions on the upper register bank ports
// assumes the cfg header is on the include path
`timescale 1ns/1ps
`include "clkgen_regs_cfg.svh"
// ==========================================================
// checker
module regs_hi_checker (
	input wire logic                      clk,
	input wire logic                      nrst,
	input wire clkgen_regs_pkg::reg_req_t req,
	input wire logic                      blk_rd_start,
	input wire logic                      bus_stop,
	input wire logic                      power_down,
	input wire logic [7:0]                rd_byte,
	input wire logic                      rd_busy,
	input wire logic [3:0]                diff_edge_fast,
	input wire logic [1:0]                ref_slew,
	input wire logic                      ref_enable,
	input wire logic [4:0]                readback_len
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic w3;
	assign w3 = req.wr && req.idx == 3'h3;
	a_reset_vals: assert property ($rose(nrst) |-> diff_edge_fast == 4'hf
		&& ref_slew == 2'h1 && readback_len == 5'h08) else $error("bad reset value");
	a_edge_write: assert property (req.wr && req.idx == 3'h2 |=>
		diff_edge_fast == $past(req.wdata[3:0])) else $error("edge write lost");
	a_slew_write: assert property (w3 |=> ref_slew == $past(req.wdata[7:6]))
		else $error("slew write lost");
	a_ref_gated: assert property (w3 && req.wdata[5:4] == 2'h1 ##1 power_down
		|=> !ref_enable) else $error("ref runs in power down");
	a_len_write: assert property (req.wr && req.idx == 3'h7 |=>
		readback_len == $past(req.wdata[4:0])) else $error("length write lost");
	a_ro_ignored: assert property (req.wr && req.idx inside {3'h4, 3'h5, 3'h6} |=>
		$stable({diff_edge_fast, ref_slew, readback_len})) else $error("fixed write took");
	a_count_first: assert property (blk_rd_start && !rd_busy |-> ##2
		rd_byte == {3'h0, readback_len} && rd_busy) else $error("count not first");
	a_busy_end: assert property (bus_stop |-> ##2 !rd_busy)
		else $error("busy after stop");
endmodule

bind clockgen_smbus_ctrl_regs_hi regs_hi_checker chk (.clk, .nrst, .req, .blk_rd_start,
	.bus_stop, .power_down, .rd_byte, .rd_busy, .diff_edge_fast, .ref_slew, .ref_enable,
	.readback_len);

// ### tb/host_model.sv
// host side: register requests and block reads
// assumes the bench samples rd_byte while smp is high
`timescale 1ns/1ps
// ==========================================================
// host
module host_model (
	input  wire logic                 clk,
	output clkgen_regs_pkg::reg_req_t req,
	output logic                      blk_rd_start,
	output logic                      blk_rd_next,
	output logic                      bus_stop,
	output logic [2:0]                blk_start_idx,
	output logic                      smp
);
	initial {req, blk_rd_start, blk_rd_next, bus_stop, blk_start_idx, smp} = '0;
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, i, d};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] i);
		@(posedge clk) req <= '{1'b0, 1'b1, i, 8'h00};
		@(posedge clk) req.rd <= 1'b0;
		@(posedge clk) smp <= 1'b1;
		@(posedge clk) smp <= 1'b0;
	endtask
	// every byte but the last is acked; the last gets a nack, then stop
	task automatic blk(input logic [2:0] i, input int n);
		@(posedge clk) {blk_rd_start, blk_start_idx} <= {1'b1, i};
		@(posedge clk) blk_rd_start <= 1'b0;
		for (int k = 0; k <= n; k++) begin
			repeat (2) @(posedge clk);
			smp <= 1'b1;
			blk_rd_next <= k != n;
			@(posedge clk) {smp, blk_rd_next} <= 2'h0;
		end
		@(posedge clk) bus_stop <= 1'b1;
		@(posedge clk) bus_stop <= 1'b0;
		// busy lags the stop; a single read while the sequencer is still active would read the walking index
		repeat (3) @(posedge clk);
	endtask
endmodule

// ### tb/test_clockgen_smbus_ctrl_regs_hi.sv
// self-checking bench for the upper register bank
// assumes host model and checker are compiled first
`timescale 1ns/1ps
`include "clkgen_regs_cfg.svh"
// ==========================================================
// bench
module test_clockgen_smbus_ctrl_regs_hi;
	logic                      clk = 1'b0;
	logic                      nrst = 1'b0;
	logic                      power_down = 1'b0;
	clkgen_regs_pkg::reg_req_t req;
	logic                      blk_rd_start, blk_rd_next, bus_stop, smp, rd_busy, ref_enable;
	logic [2:0]                blk_start_idx;
	logic [7:0]                rd_byte, m[8], exp_q[$];
	logic [3:0]                diff_edge_fast;
	logic [1:0]                ref_slew;
	logic [4:0]                readback_len;
	int                        n_errors = 0, n_checks = 0, seed = 45;
	always #5 clk = ~clk;
	host_model host (.clk, .req, .blk_rd_start, .blk_rd_next, .bus_stop, .blk_start_idx, .smp);
	clockgen_smbus_ctrl_regs_hi uut (.clk, .nrst, .req, .blk_rd_start, .blk_rd_next,
		.bus_stop, .blk_start_idx, .power_down, .rd_byte, .rd_busy, .diff_edge_fast,
		.ref_slew, .ref_enable, .readback_len);
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic note_rd(input logic [2:0] i);
		exp_q.push_back(m[i]);
		host.rd(i);
	endtask
	// model keeps only the writable bits; the rest stay fixed
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		logic [7:0] mk;
		mk = i == 3'h2 ? 8'h0f : i == 3'h3 ? 8'hf0 : i == 3'h7 ? 8'h1f : 8'h00;
		m[i] = m[i] & ~mk | d & mk;
		host.wr(i, d);
	endtask
	// ==========================================================
	// result watcher
	always @(posedge clk) if (smp === 1'b1)
		cmp(rd_byte, exp_q.size() ? exp_q.pop_front() : 8'hxx);
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
	// ==========================================================
	// scenarios
	initial begin
		m = '{8'h00, 8'h00, 8'hff, 8'h5f, 8'hff, {`REVISION_CODE, `MAKER_CODE},
			{`FAMILY_TYPE, `PART_CODE}, 8'h08};
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		#1;
		cmp({4'h0, diff_edge_fast}, 8'h0f);
		cmp({6'h0, ref_slew}, 8'h01);
		@(posedge clk) #1 cmp({7'h0, ref_enable}, 8'h01);
		cmp({3'h0, readback_len}, 8'h08);
		for (int i = 0; i < 8; i++) note_rd(3'(i));
		for (int k = 0; k < 18; k++) begin
			wr(3'(2 + k % 6), 8'($random(seed)));
			note_rd(3'(2 + k % 6));
		end
		#1 cmp({4'h0, diff_edge_fast}, m[2] & 8'h0f);
		for (int v = 0; v < 8; v++) begin
			@(posedge clk) power_down <= v[0];
			wr(3'h3, {v[1:0], v[2], v[1], 4'h0});
			@(posedge clk) #1;
			cmp({6'h0, ref_slew}, {6'h0, v[1:0]});
			cmp({7'h0, ref_enable}, {7'h0, v[1] & (~v[0] | v[2])});
		end
		power_down <= 1'b0;
		wr(3'h7, 8'h03);
		for (int s = 5; s < 7; s++) begin
			exp_q.push_back(8'h03);
			for (int k = 0; k < 3; k++) exp_q.push_back(m[(s + k) % 8]);
			host.blk(3'(s), 3);
		end
		cmp(8'(exp_q.size()), 8'h00);
		end_of_test();
	end
endmodule
